// ### hw/fault_seq_pkg.sv
// package: constants, types and timing for the supply fault sequencer
package fault_seq_pkg;
   // =====================================================================
   // clock and timing
   // =====================================================================
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned CLEAR_LOW_US = 150;        // least low time of turn-on input
   localparam int unsigned CLEAR_LOW_CYC = (CLEAR_LOW_US * (CLK_HZ / 1_000_000));
   localparam int unsigned DEGLITCH_US = 3000;        // start-up deglitch, 3 ms
   localparam int unsigned DEGLITCH_CYC = (DEGLITCH_US * (CLK_HZ / 1_000_000));
   localparam int unsigned SS_TIMEOUT_US = 2000;      // soft-start timeout, plain default
   localparam int unsigned SS_TIMEOUT_CYC = (SS_TIMEOUT_US * (CLK_HZ / 1_000_000));
   localparam int unsigned SS_DONE_US = 1000;         // soft-start ramp length, plain default
   localparam int unsigned SS_DONE_CYC = (SS_DONE_US * (CLK_HZ / 1_000_000));

   // =====================================================================
   // register map
   // =====================================================================
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] LATCH_OFS = 12'h008;
   localparam logic [11:0] RAW_OFS = 12'h00C;
   localparam int unsigned CTRL_FORCE_OFF_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // =====================================================================
   // types
   // =====================================================================
   typedef enum {
      ST_DISABLE,
      ST_SOFT_START,
      ST_NORMAL,
      ST_AUTO_PROT,
      ST_LATCHED
   } mode_t;

   // comparator flags, all active high
   typedef struct packed {
      logic in_uv;          // input undervolt_lockout falling comparator
      logic in_ov;          // input overvolt_lockout comparator
      logic main_uv;        // main_feedback_sense below undervolt trip
      logic aux_uv;         // aux_feedback_sense below undervolt trip
      logic main_ov;        // main_feedback_sense above overvolt trip
      logic aux_ov;         // aux_feedback_sense above overvolt trip
      logic failsafe_ov;    // main output above failsafe_overvolt_level
      logic pri_ot;         // primary_overtemp_trip
      logic sec_ot;         // secondary_overtemp_trip
      logic main_uvlos;     // main output above secondary lockout level
   } flags_t;

   localparam int unsigned FLAG_W = $bits(flags_t);

   // latched fault causes, kept for status
   typedef struct packed {
      logic ss_timeout;
      logic ot;
      logic failsafe_ov;
      logic ov;
      logic uv;
   } latch_cause_t;
endpackage : fault_seq_pkg

// ### hw/isolated_supply_fault_sequencer.sv
// enable, protection and power-good sequencer with an apb status port
module isolated_supply_fault_sequencer #(
   parameter int unsigned CLEAR_LOW_CYCLES = fault_seq_pkg::CLEAR_LOW_CYC,
   parameter int unsigned DEGLITCH_CYCLES = fault_seq_pkg::DEGLITCH_CYC,
   parameter int unsigned SS_TIMEOUT_CYCLES = fault_seq_pkg::SS_TIMEOUT_CYC,
   parameter int unsigned SS_DONE_CYCLES = fault_seq_pkg::SS_DONE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic turn_on_input,
   input wire fault_seq_pkg::flags_t comparator_flags,
   output logic switching_en,
   output logic soft_start_active,
   output logic power_good_n_o,
   output logic power_good_n_oe
);
   localparam int unsigned CNT_W = 24;

   fault_seq_pkg::flags_t flags_s;
   logic ena_s;
   fault_seq_pkg::mode_t mode_q;
   fault_seq_pkg::mode_t mode_d;
   fault_seq_pkg::latch_cause_t cause_q;
   logic ena_prev_q;
   logic [CNT_W-1:0] low_cnt_q;
   logic clear_armed_q;
   logic [CNT_W-1:0] ss_cnt_q;
   logic [CNT_W-1:0] dg_cnt_q;
   logic pg_issued_q;
   logic force_off_q;
   logic uv_any;
   logic ov_any;
   logic ot_any;
   logic latch_fault;
   logic latch_fault_run;
   logic clear_req;
   logic ena_eff;
   logic regulated;
   logic ss_done;
   logic ss_timeout;
   logic setup_ok;
   logic access;

   // =====================================================================
   // input synchronisation
   // =====================================================================
   // one chain for every comparator plus the turn-on pin
   // the agreement stage costs a cycle but rejects one-cycle glitches
   sync3 #(
      .WIDTH(fault_seq_pkg::FLAG_W + 1)
   ) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .async_in({comparator_flags, turn_on_input}),
      .sync_out({flags_s, ena_s})
   );

   // =====================================================================
   // fault classification
   // =====================================================================
   assign uv_any = flags_s.main_uv | flags_s.aux_uv;
   assign ov_any = flags_s.main_ov | flags_s.aux_ov;
   assign ot_any = flags_s.pri_ot | flags_s.sec_ot;
   // undervoltage trips a run only in normal mode; soft-start checks it only at exit
   assign latch_fault_run = uv_any & (mode_q == fault_seq_pkg::ST_NORMAL);
   assign latch_fault = ov_any | flags_s.failsafe_ov | ot_any;
   assign ss_done = (ss_cnt_q >= CNT_W'(SS_DONE_CYCLES));
   assign ss_timeout = (ss_cnt_q >= CNT_W'(SS_TIMEOUT_CYCLES)) & ~flags_s.main_uvlos;
   assign regulated = ~uv_any & ~ov_any; // within 10% band of both setpoints
   assign ena_eff = ena_s & ~force_off_q;
   // clear needs a long enough low phase, a rising edge and no fault still there
   assign clear_req = ena_s & ~ena_prev_q & clear_armed_q
      & ~latch_fault & ~uv_any;

   // =====================================================================
   // turn-on low-time measurement
   // =====================================================================
   // previous synced level, for the rising-edge test of a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ena_prev_q <= 1'b0;
      end else begin
         ena_prev_q <= ena_s;
      end
   end

   // low phase length; saturates so a long off time cannot wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt_q <= '0;
      end else if (ena_s) begin
         low_cnt_q <= '0;
      end else if (low_cnt_q < CNT_W'(CLEAR_LOW_CYCLES)) begin
         low_cnt_q <= low_cnt_q + CNT_W'(1);
      end
   end

   // armed flag survives the rising edge cycle, then drops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clear_armed_q <= 1'b0;
      end else if (ena_s && ena_prev_q) begin
         clear_armed_q <= 1'b0;
      end else if (!ena_s && low_cnt_q >= CNT_W'(CLEAR_LOW_CYCLES)) begin
         clear_armed_q <= 1'b1;
      end
   end

   // =====================================================================
   // operating mode
   // =====================================================================
   // input lockouts outrank everything; a latch is overridden by them too
   // a latch seen again after a lockout keeps its recorded cause
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         fault_seq_pkg::ST_DISABLE: begin
            if (flags_s.in_uv || flags_s.in_ov) begin
               mode_d = fault_seq_pkg::ST_AUTO_PROT;
            end else if (latch_fault) begin
               mode_d = fault_seq_pkg::ST_LATCHED;
            end else if (ena_eff) begin
               mode_d = fault_seq_pkg::ST_SOFT_START;
            end
         end
         fault_seq_pkg::ST_SOFT_START: begin
            if (flags_s.in_uv || flags_s.in_ov) begin
               mode_d = fault_seq_pkg::ST_AUTO_PROT;
            end else if (latch_fault || ss_timeout) begin
               mode_d = fault_seq_pkg::ST_LATCHED;
            end else if (!ena_eff) begin
               mode_d = fault_seq_pkg::ST_DISABLE;
            end else if (ss_done && flags_s.main_uvlos) begin
               // leaving soft-start with a feedback still low is a trip
               mode_d = uv_any ? fault_seq_pkg::ST_LATCHED : fault_seq_pkg::ST_NORMAL;
            end
         end
         fault_seq_pkg::ST_NORMAL: begin
            if (flags_s.in_uv || flags_s.in_ov) begin
               mode_d = fault_seq_pkg::ST_AUTO_PROT;
            end else if (latch_fault || latch_fault_run) begin
               mode_d = fault_seq_pkg::ST_LATCHED;
            end else if (!ena_eff) begin
               mode_d = fault_seq_pkg::ST_DISABLE;
            end
         end
         fault_seq_pkg::ST_AUTO_PROT: begin
            // without a recorded cause: recovery via full soft-start or wait in disable
            if (!flags_s.in_uv && !flags_s.in_ov) begin
               if (cause_q != '0) begin
                  mode_d = fault_seq_pkg::ST_LATCHED;
               end else if (ena_eff) begin
                  mode_d = fault_seq_pkg::ST_SOFT_START;
               end else begin
                  mode_d = fault_seq_pkg::ST_DISABLE;
               end
            end
         end
         fault_seq_pkg::ST_LATCHED: begin
            if (flags_s.in_uv || flags_s.in_ov) begin
               mode_d = fault_seq_pkg::ST_AUTO_PROT;
            end else if (clear_req) begin
               mode_d = fault_seq_pkg::ST_SOFT_START;
            end
         end
         default: begin
            mode_d = fault_seq_pkg::ST_DISABLE;
         end
      endcase
   end

   // the reset is the analog lockout; it wipes every latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= fault_seq_pkg::ST_DISABLE;
      end else begin
         mode_q <= mode_d;
      end
   end

   // =====================================================================
   // latched cause record
   // =====================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_q <= '0;
      end else if (mode_q == fault_seq_pkg::ST_LATCHED && mode_d == fault_seq_pkg::ST_SOFT_START) begin
         cause_q <= '0;
      end else if (mode_d == fault_seq_pkg::ST_LATCHED && mode_q != fault_seq_pkg::ST_LATCHED
                   && mode_q != fault_seq_pkg::ST_AUTO_PROT) begin
         cause_q.ss_timeout <= (mode_q == fault_seq_pkg::ST_SOFT_START) & ss_timeout;
         cause_q.ot <= ot_any;
         cause_q.failsafe_ov <= flags_s.failsafe_ov;
         cause_q.ov <= ov_any;
         cause_q.uv <= uv_any;
      end
   end

   // =====================================================================
   // soft-start timer and start-up deglitch
   // =====================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ss_cnt_q <= '0;
      end else if (mode_q != fault_seq_pkg::ST_SOFT_START) begin
         ss_cnt_q <= '0;
      end else if (ss_cnt_q != {CNT_W{1'b1}}) begin
         ss_cnt_q <= ss_cnt_q + CNT_W'(1);
      end
   end

   // deglitch count runs only while regulated, before the first power-good
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dg_cnt_q <= '0;
      end else if (mode_q != fault_seq_pkg::ST_NORMAL || pg_issued_q || !regulated) begin
         dg_cnt_q <= '0;
      end else if (dg_cnt_q < CNT_W'(DEGLITCH_CYCLES)) begin
         dg_cnt_q <= dg_cnt_q + CNT_W'(1);
      end
   end

   // first power-good of a start waits; later ones follow faults directly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pg_issued_q <= 1'b0;
      end else if (mode_q != fault_seq_pkg::ST_NORMAL) begin
         pg_issued_q <= 1'b0;
      end else if (regulated && dg_cnt_q >= CNT_W'(DEGLITCH_CYCLES)) begin
         pg_issued_q <= 1'b1;
      end
   end

   // =====================================================================
   // pin and status outputs
   // =====================================================================
   // switching follows the next mode, so a trip stops it one edge sooner
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         switching_en <= 1'b0;
         soft_start_active <= 1'b0;
      end else begin
         switching_en <= (mode_d == fault_seq_pkg::ST_SOFT_START)
            || (mode_d == fault_seq_pkg::ST_NORMAL);
         soft_start_active <= (mode_d == fault_seq_pkg::ST_SOFT_START);
      end
   end

   // open-drain: output level is always low, enable pulls the pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_good_n_o <= 1'b0;
         power_good_n_oe <= 1'b0; // pin released in reset
      end else begin
         power_good_n_o <= 1'b0;
         power_good_n_oe <= (mode_d == fault_seq_pkg::ST_NORMAL) && pg_issued_q
            && regulated && !latch_fault;
      end
   end

   // =====================================================================
   // apb slave
   // =====================================================================
   // zero wait states; setup cycles are answered in the access phase
   // unmapped offsets answer with an error and read as zero
   assign access = psel & penable;
   assign setup_ok = (paddr == fault_seq_pkg::CTRL_OFS) || (paddr == fault_seq_pkg::STATUS_OFS)
      || (paddr == fault_seq_pkg::LATCH_OFS) || (paddr == fault_seq_pkg::RAW_OFS);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         force_off_q <= fault_seq_pkg::CTRL_RESET[fault_seq_pkg::CTRL_FORCE_OFF_BIT];
      end else if (access && pwrite && paddr == fault_seq_pkg::CTRL_OFS) begin
         force_off_q <= pwdata[fault_seq_pkg::CTRL_FORCE_OFF_BIT];
      end
   end

   // handshake answer: one access cycle, never a wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~setup_ok;
      end
   end

   // read data registered in the setup cycle, valid through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else begin
         prdata <= '0;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               fault_seq_pkg::CTRL_OFS: prdata <= {31'h0000_0000, force_off_q};
               fault_seq_pkg::STATUS_OFS: prdata <= {24'h00_0000, 1'b0, pg_issued_q, ena_s,
                  switching_en, 1'b0, 3'(mode_q)};
               fault_seq_pkg::LATCH_OFS: prdata <= {27'h000_0000, cause_q};
               fault_seq_pkg::RAW_OFS: prdata <= {{(32 - fault_seq_pkg::FLAG_W){1'b0}}, flags_s};
               default: prdata <= '0;
            endcase
         end
      end
   end
endmodule : isolated_supply_fault_sequencer

// ### hw/sync3.sv
// three-stage synchroniser for a bus of asynchronous levels
module sync3 #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   // =====================================================================
   // per-bit chain; change accepted when stages two and three agree
   // =====================================================================
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_q[i] <= 1'b0;
               s2_q[i] <= 1'b0;
               s3_q[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               s1_q[i] <= async_in[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               // hold until the two later stages agree, filters one-cycle glitches
               if (s2_q[i] == s3_q[i]) begin
                  sync_out[i] <= s3_q[i];
               end
            end
         end
      end
   endgenerate
endmodule : sync3

// ### tb/fault_seq_chk.sv
// checker: port-level assertions for the supply fault sequencer
module fault_seq_chk #(
   parameter int unsigned SS_TIMEOUT_CYCLES = 200,
   parameter int unsigned DEGLITCH_CYCLES = 30
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic turn_on_input,
   input wire fault_seq_pkg::flags_t comparator_flags,
   input wire logic switching_en,
   input wire logic soft_start_active,
   input wire logic power_good_n_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned ss_cnt_q;
   int unsigned run_cnt_q;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // =====================================================================
   // helper counters
   // =====================================================================
   // run lengths of soft-start and of plain running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ss_cnt_q <= 0;
         run_cnt_q <= 0;
      end else begin
         ss_cnt_q <= soft_start_active ? ss_cnt_q + 1 : 0;
         run_cnt_q <= (switching_en && !soft_start_active) ? run_cnt_q + 1 : 0;
      end
   end
   // =====================================================================
   // properties
   // =====================================================================
   // eight samples cover the sync chain plus the output flop
   sequence s_held(logic x);
      x [*8];
   endsequence
   sequence s_setup;
      psel && !penable;
   endsequence
   a_off_stop: assert property (s_held(!turn_on_input) |-> !switching_en)
      else $error("switching while turned off");
   a_inuv_stop: assert property (s_held(comparator_flags.in_uv) |-> !switching_en)
      else $error("switching in input undervoltage");
   a_inov_stop: assert property (s_held(comparator_flags.in_ov) |-> !switching_en)
      else $error("switching in input overvoltage");
   a_ov_stop: assert property (s_held(comparator_flags.main_ov || comparator_flags.aux_ov) |-> !switching_en)
      else $error("switching in output overvoltage");
   a_failsafe_stop: assert property (s_held(comparator_flags.failsafe_ov) |-> !switching_en)
      else $error("switching in failsafe overvoltage");
   a_ot_stop: assert property (s_held(comparator_flags.pri_ot || comparator_flags.sec_ot) |->
      !switching_en && !power_good_n_oe)
      else $error("running in overtemperature");
   a_uv_pg: assert property (s_held(comparator_flags.main_uv || comparator_flags.aux_uv) |-> !power_good_n_oe)
      else $error("power good with undervoltage");
   a_pg_normal: assert property (power_good_n_oe |-> switching_en && !soft_start_active)
      else $error("power good outside normal run");
   a_ss_switch: assert property (soft_start_active |-> switching_en)
      else $error("soft-start without switching");
   a_start_cause: assert property ($rose(switching_en) |-> $past(turn_on_input, 3))
      else $error("switching began without turn-on");
   a_pg_deglitch: assert property ($rose(power_good_n_oe) |-> run_cnt_q >= DEGLITCH_CYCLES)
      else $error("power good before deglitch");
   a_ss_bound: assert property (ss_cnt_q <= SS_TIMEOUT_CYCLES + 2)
      else $error("soft-start outlived its timeout");
   a_apb_answer: assert property (s_setup |=> pready ##1 !pready)
      else $error("apb answer not one access cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("slave error without ready");
endmodule : fault_seq_chk

bind isolated_supply_fault_sequencer fault_seq_chk #(
   .SS_TIMEOUT_CYCLES(SS_TIMEOUT_CYCLES),
   .DEGLITCH_CYCLES(DEGLITCH_CYCLES)
) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .turn_on_input(turn_on_input), .comparator_flags(comparator_flags),
   .switching_en(switching_en), .soft_start_active(soft_start_active), .power_good_n_oe(power_good_n_oe));

// ### tb/host_ctrl_model.sv
// host controller model: drives turn-on input, reads the power-good pin
module host_ctrl_model (
   input wire logic pclk,
   input wire logic power_good_n_o,
   input wire logic power_good_n_oe,
   output logic turn_on_input,
   output logic pg_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // open drain with pull-up: a released pin reads high
   assign pg_pin = power_good_n_oe ? power_good_n_o : 1'b1;
   initial turn_on_input = 1'b0;
   // level change just after a rising edge
   task automatic drive(input logic v);
      @(posedge pclk);
      turn_on_input <= v;
   endtask : drive
   // off-then-on; only a low longer than the minimum clears a latch
   task automatic toggle(input int low_cyc);
      drive(1'b0);
      repeat (low_cyc) @(posedge pclk);
      drive(1'b1);
   endtask : toggle
endmodule : host_ctrl_model

// ### tb/isolated_supply_fault_sequencer_tb_top.sv
// testbench: host-side stimulus checked against scripted expected modes
module isolated_supply_fault_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned CLR = fault_seq_pkg::CLEAR_LOW_CYC;
   localparam int unsigned DGL = 30;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic turn_on_input, switching_en, soft_start_active, pg_o, pg_oe, pg_pin;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   fault_seq_pkg::flags_t flags;
   int num_errors = 0;
   int checks_done = 0;
   // latching faults and the cause bit each records
   logic [9:0] masks [7] = '{10'h080, 10'h040, 10'h020, 10'h010, 10'h008, 10'h004, 10'h002};
   int cause [7] = '{0, 0, 1, 1, 2, 3, 3};
   // short counts keep the run brief
   isolated_supply_fault_sequencer #(.DEGLITCH_CYCLES(DGL), .SS_TIMEOUT_CYCLES(200),
      .SS_DONE_CYCLES(50)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .turn_on_input(turn_on_input), .comparator_flags(flags), .switching_en(switching_en),
      .soft_start_active(soft_start_active), .power_good_n_o(pg_o), .power_good_n_oe(pg_oe));
   host_ctrl_model host (.pclk(pclk), .power_good_n_o(pg_o), .power_good_n_oe(pg_oe),
      .turn_on_input(turn_on_input), .pg_pin(pg_pin));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude
   task automatic fail(input string what);
      num_errors++;
      $display("Error %s timed out", what);
      conclude();
   endtask : fail
   // one apb transfer; request held until pready is sampled
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) fail("pready");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // poll status until the expected mode shows, then compare the ports
   task automatic expect_mode(input int m);
      int n;
      for (n = 0; n < 700; n++) begin
         apb(1'b0, fault_seq_pkg::STATUS_OFS, 32'h0);
         if (rd[2:0] === 3'(m)) break;
      end
      if (n == 700) fail("mode");
      check("mode", 32'(rd[2:0]), 32'(m));
      check("switching_en", 32'(switching_en), 32'(m == 1 || m == 2));
      if (m != 2) check("pg_pin", 32'(pg_pin), 32'h1);
   endtask : expect_mode
   initial begin
      int i;
      seed = 32'h45EB;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      flags = '0;
      flags.main_uvlos = 1'b1;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      // reset values and a refused address
      apb(1'b0, fault_seq_pkg::CTRL_OFS, 32'h0);
      check("ctrl", rd, fault_seq_pkg::CTRL_RESET);
      apb(1'b0, fault_seq_pkg::LATCH_OFS, 32'h0);
      check("latch", rd, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      check("pslverr", 32'(er), 32'h1);
      check("unmapped", rd, 32'h0);
      expect_mode(0);
      // start-up, then power good once the deglitch has run
      host.drive(1'b1);
      expect_mode(1);
      expect_mode(2);
      repeat (DGL + 8) @(posedge pclk);
      check("pg_pin", 32'(pg_pin), 32'h0);
      // input lockouts recover on their own
      for (i = 0; i < 2; i++) begin
         flags[9 - i] <= 1'b1;
         expect_mode(3);
         flags[9 - i] <= 1'b0;
         expect_mode(2);
      end
      host.drive(1'b0);
      expect_mode(0);
      host.drive(1'b1);
      expect_mode(2);
      // random control word with force-off set, then cleared
      seed = lfsr(seed);
      apb(1'b1, fault_seq_pkg::CTRL_OFS, seed | 32'h1);
      apb(1'b0, fault_seq_pkg::CTRL_OFS, 32'h0);
      check("ctrl", rd, 32'h1);
      expect_mode(0);
      apb(1'b1, fault_seq_pkg::CTRL_OFS, seed & 32'hFFFF_FFFE);
      expect_mode(2);
      // each latching fault; a short low must not clear it
      for (i = 0; i < 7; i++) begin
         flags <= fault_seq_pkg::flags_t'(flags | masks[i]);
         expect_mode(4);
         apb(1'b0, fault_seq_pkg::LATCH_OFS, 32'h0);
         check("cause", 32'(rd[cause[i]]), 32'h1);
         if (i > 4) begin
            host.toggle(CLR + 10);
            repeat (20) @(posedge pclk);
            expect_mode(4);
         end
         flags <= fault_seq_pkg::flags_t'(flags & ~masks[i]);
         seed = lfsr(seed);
         host.toggle(2 + int'(seed % (CLR / 2)));
         if (i == 0) begin
            flags.in_ov <= 1'b1;
            repeat (12) @(posedge pclk);
            flags.in_ov <= 1'b0;
         end
         repeat (20) @(posedge pclk);
         expect_mode(4);
         host.toggle(CLR + 10);
         expect_mode(2);
      end
      // lockout level never reached: soft-start times out
      host.drive(1'b0);
      expect_mode(0);
      flags.main_uvlos <= 1'b0;
      host.drive(1'b1);
      expect_mode(4);
      apb(1'b0, fault_seq_pkg::LATCH_OFS, 32'h0);
      check("cause", 32'(rd[4]), 32'h1);
      // supply cycle clears every latch and follows turn-on
      flags.main_uvlos <= 1'b1;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      expect_mode(2);
      apb(1'b0, fault_seq_pkg::LATCH_OFS, 32'h0);
      check("latch", rd, 32'h0);
      conclude();
   end
endmodule : isolated_supply_fault_sequencer_tb_top
